/* hdl/tsc_regs.vh */
`ifndef TSC_REGS_VH
`define TSC_REGS_VH

// register byte offsets on the axi4-lite slave
`define TSC_OFF_SEC 8'h00
`define TSC_OFF_MSW 8'h04
`define TSC_OFF_SYNC 8'h08
`define TSC_OFF_CONV 8'h0C
`define TSC_OFF_CAL1 8'h10
`define TSC_OFF_CAL2 8'h14
`define TSC_OFF_CAL3 8'h18
`define TSC_OFF_CAL4 8'h1C
`define TSC_OFF_CALQ 8'h20
`define TSC_OFF_SVAL 8'h24
`define TSC_OFF_STAT 8'h28

// millisecond word field positions
`define TSC_MS_LSB 0
`define TSC_MS_MSB 9
`define TSC_BIT_EXT 12
`define TSC_BIT_INT 13
`define TSC_BIT_SET 14

// conversion control and status field positions
`define TSC_CONV_START 0
`define TSC_CONV_BUSY 0
`define TSC_CONV_DONE 1
`define TSC_DOY_LSB 16

// calendar field positions
`define TSC_MON_LSB 8
`define TSC_HR_LSB 8

// reset values
`define TSC_RST_SEC 32'h0000_0000
`define TSC_RST_ZERO 32'h0000_0000

// axi response codes
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2

// timing: clock period and time spans in their own units
`define TSC_CLK_NS 10
`define TSC_MS_NS 1000000
`define TSC_MS_CYC (`TSC_MS_NS / `TSC_CLK_NS)
`define TSC_MS_PER_S 1000
`define TSC_EXT_HOLD_H 2
`define TSC_EXT_HOLD_S (`TSC_EXT_HOLD_H * 3600)

// calendar arithmetic
`define TSC_S_PER_DAY 32'd86400
`define TSC_S_PER_HR 32'd3600
`define TSC_S_PER_MIN 32'd60
`define TSC_D_PER_YR 16'd365
`define TSC_D_PER_LYR 16'd366
`define TSC_NOLEAP_YR 7'd100

`endif

/* hdl/tsc_timestamp.v */
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "tsc_regs.vh"

// Functional notes
// - calendar word one: year minus 2000, bits 0-6
// - day/month, minute/hour, millisecond-of-minute words
// - quality word flags ext, sync, date set
// - validity word precedes enumerated status word
// - seconds count, high word first
// - milliseconds in bits 0-9 of third word
// - bit 12: external sync within two hours
// - bit 13: internally synchronized flag
// - bit 14: date set since power-up
// - power loss restarts seconds at zero
// - external sync loads seconds count
// - leap every fourth year except 2100
module tsc_timestamp #(
  parameter MS_CYCLES = `TSC_MS_CYC,
  parameter EXT_HOLD_S = `TSC_EXT_HOLD_S
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire int_sync_in,
  input wire [15:0] open_closed_contact,
  input wire [15:0] contact_valid
);

  // converter states, one-hot
  localparam ST_IDLE = 6'b000001;
  localparam ST_DAYS = 6'b000010;
  localparam ST_YEARS = 6'b000100;
  localparam ST_MONS = 6'b001000;
  localparam ST_HRS = 6'b010000;
  localparam ST_MINS = 6'b100000;

  reg [31:0] ms_div_q;
  reg [9:0] ms_q;
  reg [31:0] sec_q;
  reg ext_ok_q;
  reg [31:0] ext_age_q;
  reg int_done_q;
  reg date_set_q;
  reg [15:0] ms_shadow_q;
  reg [32:0] sync_s1_q;
  reg [32:0] sync_s2_q;
  reg [32:0] sync_s3_q;
  reg [32:0] pins_q;
  reg int_prev_q;
  reg [5:0] st_q;
  reg [31:0] cv_sec_q;
  reg [15:0] cv_days_q;
  reg [6:0] cv_year_q;
  reg [3:0] cv_mon_q;
  reg [4:0] cv_hr_q;
  reg [5:0] cv_min_q;
  reg [9:0] cv_ms_q;
  reg [8:0] cv_doy_q;
  reg conv_done_q;
  reg [15:0] cal1_q;
  reg [15:0] cal2_q;
  reg [15:0] cal3_q;
  reg [15:0] cal4_q;
  reg [15:0] calq_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_d;
  reg rd_err_d;
  wire ms_wrap;
  wire do_write;
  wire ar_hs;
  wire sync_wr;
  wire start_wr;
  wire [31:0] sync_val;
  wire [15:0] ms_word;
  wire cv_leap;
  wire [15:0] cv_ylen;
  wire [15:0] cv_mlen;
  wire [31:0] cv_msmin;

  // month length for the month being stepped over
  function [15:0] mon_len;
    input [3:0] mon;
    input leap;
    begin
      case (mon)
        4'h2: mon_len = leap ? 16'd29 : 16'd28;
        4'h4, 4'h6, 4'h9, 4'hB: mon_len = 16'd30;
        default: mon_len = 16'd31;
      endcase
    end
  endfunction

  assign ms_wrap = (ms_div_q == MS_CYCLES - 1) && (ms_q == 10'd999);
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign sync_wr = do_write && (awaddr_q == `TSC_OFF_SYNC);
  assign start_wr = do_write && (awaddr_q == `TSC_OFF_CONV) && wstrb_q[0] &&
    wdata_q[`TSC_CONV_START];
  // byte lanes merge new sync value over the running count
  assign sync_val = {wstrb_q[3] ? wdata_q[31:24] : sec_q[31:24],
    wstrb_q[2] ? wdata_q[23:16] : sec_q[23:16],
    wstrb_q[1] ? wdata_q[15:8] : sec_q[15:8],
    wstrb_q[0] ? wdata_q[7:0] : sec_q[7:0]};
  // millisecond word: ms, ext, int, date-set; bits 10,11,15 read zero
  assign ms_word = {1'b0, date_set_q, int_done_q, ext_ok_q, 2'b00, ms_q};
  assign cv_leap = (cv_year_q[1:0] == 2'b00) && (cv_year_q != `TSC_NOLEAP_YR);
  assign cv_ylen = cv_leap ? `TSC_D_PER_LYR : `TSC_D_PER_YR;
  assign cv_mlen = mon_len(cv_mon_q, cv_leap);
  assign cv_msmin = cv_sec_q * 32'd1000 + {22'd0, cv_ms_q};

  // millisecond divider and seconds counter; reset is the power loss
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_div_q <= `TSC_RST_ZERO;
      ms_q <= 10'd0;
      sec_q <= `TSC_RST_SEC;
    end else if (sync_wr) begin
      ms_div_q <= `TSC_RST_ZERO;
      ms_q <= 10'd0;
      sec_q <= sync_val;
    end else if (ms_div_q == MS_CYCLES - 1) begin
      ms_div_q <= `TSC_RST_ZERO;
      ms_q <= (ms_q == 10'd999) ? 10'd0 : ms_q + 10'd1;
      if (ms_wrap) begin
        sec_q <= sec_q + 32'd1;
      end
    end else begin
      ms_div_q <= ms_div_q + 32'd1;
    end
  end

  // three-stage pin sampling; a change counts when stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_s1_q <= 33'd0;
      sync_s2_q <= 33'd0;
      sync_s3_q <= 33'd0;
      pins_q <= 33'd0;
      int_prev_q <= 1'b0;
    end else begin
      sync_s1_q <= {int_sync_in, contact_valid, open_closed_contact};
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
      if (sync_s2_q == sync_s3_q) begin
        pins_q <= sync_s3_q;
      end
      int_prev_q <= pins_q[32];
    end
  end

  // quality flags; a new sync wins over the two-hour expiry
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_ok_q <= 1'b0;
      ext_age_q <= `TSC_RST_ZERO;
      int_done_q <= 1'b0;
      date_set_q <= 1'b0;
    end else begin
      if (sync_wr) begin
        ext_ok_q <= 1'b1;
        ext_age_q <= `TSC_RST_ZERO;
        date_set_q <= 1'b1;
      end else if (ext_ok_q && ms_wrap) begin
        ext_age_q <= ext_age_q + 32'd1;
        if (ext_age_q == EXT_HOLD_S - 1) begin
          ext_ok_q <= 1'b0;
        end
      end
      if (pins_q[32] && !int_prev_q) begin
        int_done_q <= 1'b1;
      end
    end
  end

  // calendar converter by repeated subtraction, one step per cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      cv_sec_q <= `TSC_RST_ZERO;
      cv_days_q <= 16'd0;
      cv_year_q <= 7'd0;
      cv_mon_q <= 4'd1;
      cv_hr_q <= 5'd0;
      cv_min_q <= 6'd0;
      cv_ms_q <= 10'd0;
      cv_doy_q <= 9'd0;
      conv_done_q <= 1'b0;
      cal1_q <= 16'h0000;
      cal2_q <= 16'h0000;
      cal3_q <= 16'h0000;
      cal4_q <= 16'h0000;
      calq_q <= 16'h0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start_wr) begin
            cv_sec_q <= sec_q;
            cv_ms_q <= ms_q;
            cv_days_q <= 16'd0;
            cv_year_q <= 7'd0;
            cv_hr_q <= 5'd0;
            cv_min_q <= 6'd0;
            conv_done_q <= 1'b0;
            st_q <= ST_DAYS;
          end
        end
        ST_DAYS: begin
          if (cv_sec_q >= `TSC_S_PER_DAY) begin
            cv_sec_q <= cv_sec_q - `TSC_S_PER_DAY;
            cv_days_q <= cv_days_q + 16'd1;
          end else begin
            st_q <= ST_YEARS;
          end
        end
        ST_YEARS: begin
          if (cv_days_q >= cv_ylen) begin
            cv_days_q <= cv_days_q - cv_ylen;
            cv_year_q <= cv_year_q + 7'd1;
          end else begin
            cv_doy_q <= cv_days_q[8:0] + 9'd1;
            cv_mon_q <= 4'd1;
            st_q <= ST_MONS;
          end
        end
        ST_MONS: begin
          if (cv_days_q >= cv_mlen) begin
            cv_days_q <= cv_days_q - cv_mlen;
            cv_mon_q <= cv_mon_q + 4'd1;
          end else begin
            st_q <= ST_HRS;
          end
        end
        ST_HRS: begin
          if (cv_sec_q >= `TSC_S_PER_HR) begin
            cv_sec_q <= cv_sec_q - `TSC_S_PER_HR;
            cv_hr_q <= cv_hr_q + 5'd1;
          end else begin
            st_q <= ST_MINS;
          end
        end
        ST_MINS: begin
          if (cv_sec_q >= `TSC_S_PER_MIN) begin
            cv_sec_q <= cv_sec_q - `TSC_S_PER_MIN;
            cv_min_q <= cv_min_q + 6'd1;
          end else begin
            cal1_q <= {9'd0, cv_year_q};
            cal2_q <= {4'd0, cv_mon_q, 3'd0, cv_days_q[4:0] + 5'd1};
            cal3_q <= {3'd0, cv_hr_q, 2'd0, cv_min_q};
            cal4_q <= cv_msmin[15:0];
            calq_q <= {1'b0, date_set_q, int_done_q, ext_ok_q, 12'h000};
            conv_done_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // write channel: address and data taken in either order, one write at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSC_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= `TSC_RST_ZERO;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `TSC_OFF_SYNC || awaddr_q == `TSC_OFF_CONV) ?
          `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read decode
  always @* begin
    rd_d = `TSC_RST_ZERO;
    rd_err_d = 1'b0;
    case (s_axi_araddr[7:0])
      `TSC_OFF_SEC: rd_d = sec_q;
      `TSC_OFF_MSW: rd_d = {16'h0000, ms_shadow_q};
      `TSC_OFF_SYNC: rd_d = sec_q;
      `TSC_OFF_CONV: rd_d = {7'd0, cv_doy_q, 14'd0, conv_done_q, st_q != ST_IDLE};
      `TSC_OFF_CAL1: rd_d = {16'h0000, cal1_q};
      `TSC_OFF_CAL2: rd_d = {16'h0000, cal2_q};
      `TSC_OFF_CAL3: rd_d = {16'h0000, cal3_q};
      `TSC_OFF_CAL4: rd_d = {16'h0000, cal4_q};
      `TSC_OFF_CALQ: rd_d = {16'h0000, calq_q};
      `TSC_OFF_SVAL: rd_d = {16'h0000, pins_q[31:16]};
      `TSC_OFF_STAT: rd_d = {16'h0000, pins_q[15:0]};
      default: rd_err_d = 1'b1;
    endcase
  end

  // read channel; reading the seconds count freezes the matching ms word
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `TSC_RST_ZERO;
      s_axi_rresp <= `TSC_RESP_OKAY;
      ms_shadow_q <= 16'h0000;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_err_d ? `TSC_RESP_SLVERR : `TSC_RESP_OKAY;
        if (s_axi_araddr[7:0] == `TSC_OFF_SEC) begin
          ms_shadow_q <= ms_word;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // tsc_timestamp

/* tb/tsc_timestamp_asserts.sv */
`timescale 1ns/1ps
`include "tsc_regs.vh"
module tsc_timestamp_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  reg [7:0] ra_q;
  // remember the address of the read in flight
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr[7:0];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  idle_after_reset_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready
    && !s_axi_bvalid && !s_axi_rvalid) else $error("bus not idle after reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read answer late");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > 8'h28
    |=> s_axi_rresp == `TSC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read ok");
  ms_field_a: assert property (s_axi_rvalid && ra_q == `TSC_OFF_MSW |->
    s_axi_rdata[9:0] <= 10'h3E7 && s_axi_rdata[11:10] == 2'h0 && !s_axi_rdata[15])
    else $error("ms word bad");
  year_word_a: assert property (s_axi_rvalid && ra_q == `TSC_OFF_CAL1 |->
    s_axi_rdata[31:7] == 25'h0) else $error("year word bad");
  time_word_a: assert property (s_axi_rvalid && ra_q == `TSC_OFF_CAL3 |->
    s_axi_rdata[5:0] <= 6'h3B && s_axi_rdata[12:8] <= 5'h17) else $error("time word bad");
  qual_word_a: assert property (s_axi_rvalid && ra_q == `TSC_OFF_CALQ |->
    s_axi_rdata[11:0] == 12'h0 && s_axi_rdata[31:15] == 17'h0) else $error("quality bad");
endmodule // tsc_timestamp_asserts
bind tsc_timestamp tsc_timestamp_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);

/* tb/tsc_host.sv */
`timescale 1ns/1ps
module tsc_host (
  input wire aclk,
  output reg [31:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  output reg [31:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
  end
  // one write: address and data offered together, each released when taken
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    reg aw, w;
    begin
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
        @(posedge aclk);
        if (aw && s_axi_awready) begin
          aw = 1'b0;
          s_axi_awvalid <= 1'b0;
        end
        if (w && s_axi_wready) begin
          w = 1'b0;
          s_axi_wvalid <= 1'b0;
        end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  // one read: hold the address until taken, data taken at the rvalid edge
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule // tsc_host

/* tb/tsc_timestamp_tb.sv */
`timescale 1ns/1ps
`include "tsc_regs.vh"
module tsc_timestamp_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg int_sync_in = 1'b0;
  reg [15:0] open_closed_contact = 16'h0;
  reg [15:0] contact_valid = 16'h0;
  wire [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [3:0] s_axi_wstrb = 4'hF;
  integer mismatches = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] d;
  reg [1:0] r;
  reg [31:0] t_sec [0:1];
  reg [31:0] t_cal [0:1][0:5];
  tsc_timestamp #(.MS_CYCLES(10), .EXT_HOLD_S(3)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .int_sync_in, .open_closed_contact, .contact_valid);
  tsc_host host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // clock and hang guard
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        $display("wrong value %s expected %h seen %h", nm, e, g);
        mismatches = mismatches + 1;
      end
    end
  endtask
  // masked read compare, response must be okay
  task rdc(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      host_u.rd(a, d, r);
      chk($sformatf("reg %h", a), e, d & m);
      chk("rresp", {30'h0, `TSC_RESP_OKAY}, {30'h0, r});
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    // 2008-03-01 12:34:56 and 2100-03-01 23:59:30: year, day/month, time, ms, doy, quality
    t_sec[0] = 32'h0F5C_09F0;
    t_sec[1] = 32'hBC68_2D62;
    t_cal[0] = '{32'h8, 32'h301, 32'hC22, 32'hDAC0, 32'h3D, 32'h7000};
    t_cal[1] = '{32'h64, 32'h301, 32'h173B, 32'h7530, 32'h3C, 32'h6000};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`TSC_OFF_SEC, 32'h0, 32'hFFFF_FFFF);
    rdc(`TSC_OFF_MSW, 32'h0, 32'h7000);
    open_closed_contact <= 16'h0F0F;
    contact_valid <= 16'hA5C3;
    repeat (8) @(posedge aclk);
    rdc(`TSC_OFF_SVAL, 32'hA5C3, 32'hFFFF_FFFF);
    rdc(`TSC_OFF_STAT, 32'h0F0F, 32'hFFFF_FFFF);
    host_u.rd(8'h2C, d, r);
    chk("bad rresp", {30'h0, `TSC_RESP_SLVERR}, {30'h0, r});
    host_u.wr(`TSC_OFF_SEC, 32'h1234, r);
    chk("sec bresp", {30'h0, `TSC_RESP_SLVERR}, {30'h0, r});
    rdc(`TSC_OFF_SEC, 32'h0, 32'hFFFF_FFFF);
    int_sync_in <= 1'b1;
    $display("test reset and pins done");
    // conversion across leap and non-leap march 1st; day of year sits in bits 24:16
    for (i = 0; i < 2; i = i + 1) begin
      host_u.wr(`TSC_OFF_SYNC, t_sec[i], r);
      host_u.wr(`TSC_OFF_CONV, 32'h1, r);
      do host_u.rd(`TSC_OFF_CONV, d, r); while (d[0] !== 1'b0 && cyc < 90000);
      chk("doy", (t_cal[i][4] << 16) | 32'h2, d & 32'h01FF_0003);
      rdc(`TSC_OFF_CAL1, t_cal[i][0], 32'hFFFF_FFFF);
      rdc(`TSC_OFF_CAL2, t_cal[i][1], 32'hFFFF_FFFF);
      rdc(`TSC_OFF_CAL3, t_cal[i][2], 32'hFFFF_FFFF);
      host_u.rd(`TSC_OFF_CAL4, d, r);
      chk("cal4", 32'h1, {31'h0, d - t_cal[i][3] < 32'h2});
      rdc(`TSC_OFF_CALQ, t_cal[i][5], 32'hFFFF_FFFF);
    end
    $display("test conversion done");
    host_u.wr(`TSC_OFF_SYNC, 32'h0001_1000, r);
    repeat (9000) @(posedge aclk);
    rdc(`TSC_OFF_SEC, 32'h0001_1000, 32'hFFFF_FFFF);
    host_u.rd(`TSC_OFF_MSW, d, r);
    chk("msw flags", 32'h7000, d & 32'hFFFF_FC00);
    chk("ms", 32'h1, {31'h0, d[9:0] - 10'h384 < 10'h3});
    repeat (2000) @(posedge aclk);
    rdc(`TSC_OFF_SEC, 32'h0001_1001, 32'hFFFF_FFFF);
    repeat (20000) @(posedge aclk);
    rdc(`TSC_OFF_SEC, 32'h0001_1003, 32'hFFFF_FFFF);
    rdc(`TSC_OFF_MSW, 32'h6000, 32'h7000);
    $display("test counting done");
    int_sync_in <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`TSC_OFF_SEC, 32'h0, 32'hFFFF_FFFF);
    rdc(`TSC_OFF_MSW, 32'h0, 32'h7000);
    $display("test power loss done");
    give_verdict;
  end
endmodule // tsc_timestamp_tb
